/* include/vel_defs.svh */
// Register offsets, field positions, reset values and limits of the element layout block
`ifndef VEL_DEFS_SVH
`define VEL_DEFS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define VEL_OFF_CFG 8'h00
`define VEL_OFF_STATUS 8'h04
`define VEL_OFF_VLENB 8'h08
`define VEL_OFF_SWAPS 8'h0C

// ==========================================================
// Configuration register fields
`define VEL_CFG_SEW_LSB 0
`define VEL_CFG_SEW_MSB 1
`define VEL_CFG_REGISTER_GROUP_MULTIPLIER_LSB 2
`define VEL_CFG_REGISTER_GROUP_MULTIPLIER_MSB 4
`define VEL_CFG_TA_BIT 5
`define VEL_CFG_RST 6'h00

// ==========================================================
// Status register fields
`define VEL_ST_LEGAL_BIT 0
`define VEL_ST_ERR_BIT 1
`define VEL_ST_CONFLICT_BIT 2
`define VEL_ST_MAX_ELEMENT_COUNT_LSB 16

// ==========================================================
// Encodings and limits
`define VEL_REGISTER_GROUP_MULTIPLIER_RSVD 3'h4
`define VEL_MAX_RATIO_LOG2 6
`define VEL_NUM_REGS 32

`endif

/* include/vel_pkg.sv */
// Types shared by the element layout block and its users
package vel_pkg;

	// ==========================================================
	// Element width code, bits = 8 << code
	typedef enum logic [1:0] {
		VEL_E8 = 2'h0,
		VEL_E16 = 2'h1,
		VEL_E32 = 2'h2,
		VEL_E64 = 2'h3
	} vel_sew_t;

	// ==========================================================
	// Live layout setting: tail policy, grouping code, element width
	typedef struct packed {
		logic ta;
		logic [2:0] register_group_multiplier;
		vel_sew_t selected_element_width;
	} vel_cfg_t;

	// Element access request from the datapath
	typedef struct packed {
		logic [4:0] vreg;
		logic [15:0] idx;
		logic [63:0] wdata;
	} vel_elem_req_t;

endpackage

/* verilog/vel_locate.sv */
// Element index to physical register and bit position translation
`timescale 1ns/10ps
`include "vel_defs.svh"

module vel_locate #(
	parameter int VECTOR_REGISTER_BITS = 128
) (
	input wire vel_pkg::vel_cfg_t cfg_in,
	input wire logic [4:0] vreg_in,
	input wire logic [15:0] idx_in,
	output logic [4:0] preg_out,
	output logic [$clog2(VECTOR_REGISTER_BITS)-1:0] boff_out,
	output logic [16:0] max_element_count_out,
	output logic legal_out,
	output logic ok_out
);
	localparam int VL2 = $clog2(VECTOR_REGISTER_BITS);

	// Signed log2 of the grouping multiplier, codes 5..7 are 1/8..1/2
	function automatic int register_group_multiplier_log2(input logic [2:0] code);
		register_group_multiplier_log2 = code[2] ? int'(code) - 8 : int'(code);
	endfunction

	// ==========================================================
	// Translation
	// Byte offset of the element inside the group picks the member register,
	// the remainder is its bit position, so lower bytes sit at lower bits
	always_comb begin
		int l;
		int s;
		int vl2;
		logic [31:0] boff;
		logic [31:0] gmask;
		l = register_group_multiplier_log2(cfg_in.register_group_multiplier);
		s = int'(cfg_in.selected_element_width);
		vl2 = VL2 + l - 3 - s;
		legal_out = (cfg_in.register_group_multiplier != `VEL_REGISTER_GROUP_MULTIPLIER_RSVD) && (3 + s - l <= `VEL_MAX_RATIO_LOG2);
		max_element_count_out = (legal_out && vl2 >= 0) ? 17'(32'h1 << vl2) : 17'h0;
		boff = 32'(idx_in) << s;
		preg_out = vreg_in + 5'(boff >> (VL2 - 3));
		boff_out = VL2'((boff << 3) % VECTOR_REGISTER_BITS);
		gmask = (l > 0) ? (32'h1 << l) - 32'h1 : 32'h0;
		// Groups start on a multiple of their size and never wrap past v31
		ok_out = legal_out && (17'(idx_in) < max_element_count_out) && ((32'(vreg_in) & gmask) == 32'h0);
	end

endmodule

/* verilog/vel_eew_track.sv */
// Per-register record of the width each register was last written with
`timescale 1ns/10ps

module vel_eew_track #(
	parameter int NREG = 32
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [4:0] preg_in,
	input wire vel_pkg::vel_sew_t eew_in,
	output logic swap_out
);
	vel_pkg::vel_sew_t tag_q [NREG];

	// ==========================================================
	// Tag update: the write width becomes the register's stored layout
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < NREG; i++) begin
				tag_q[i] <= vel_pkg::VEL_E8;
			end
		end else if (wr_in) begin
			tag_q[preg_in] <= eew_in;
		end
	end

	// Width mismatch marks a scrambling step; storage stays canonical so it is unseen
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			swap_out <= 1'b0;
		end else begin
			swap_out <= (wr_in || rd_in) && (tag_q[preg_in] != eew_in);
		end
	end

endmodule

/* verilog/vel_layout.sv */
// Vector register file with element, mask and tail access by index
//
// How it works
// - Every element stores its lowest byte in the lowest bits of its slot.
// - Bits inside an element count upward in magnitude from bit zero.
// - With a group of one, element i sits at bit i times the width.
// - With a fractional group only the first multiplier times length over width slots are used.
// - The unused upper part of a fractional register is tail and follows the tail policy.
// - In a larger group elements fill the lowest register first, then the next.
// - Any internal rearrangement by width stays invisible to software.
// - The width each register was last written with is tracked and a mismatch is marked.
// - Widths 8 to 64 with ratios 1 to 64 and multipliers 1/8 to 8 are legal settings.
// - A mask always lives in exactly one register.
// - The mask bit of element i is bit i of the mask register.
`timescale 1ns/10ps
`include "vel_defs.svh"

module vel_layout #(
	parameter int VECTOR_REGISTER_BITS = 128
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Register port
	input wire logic [7:0] bus_addr_in,
	input wire logic [31:0] bus_wdata_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	output logic [31:0] bus_rdata_out,
	// Element port
	input wire logic elem_wr_in,
	input wire logic elem_rd_in,
	input wire vel_pkg::vel_elem_req_t elem_req_in,
	output logic [63:0] elem_rdata_out,
	output logic elem_rvalid_out,
	output logic elem_err_out,
	// Mask port
	input wire logic mask_wr_in,
	input wire logic mask_rd_in,
	input wire logic [4:0] mask_reg_in,
	input wire logic [15:0] mask_idx_in,
	input wire logic mask_bit_in,
	output logic mask_bit_out,
	output logic mask_valid_out,
	// Tail fill port
	input wire logic tail_fill_in,
	input wire logic [4:0] tail_reg_in,
	// Live setting for the datapath
	output vel_pkg::vel_cfg_t cfg_out,
	output logic [16:0] max_element_count_out
);
	localparam int VL2 = $clog2(VECTOR_REGISTER_BITS);
	localparam int NREG = `VEL_NUM_REGS;

	logic rst_s1_q;
	logic rst_s2_q;
	logic rst_n;
	logic [VECTOR_REGISTER_BITS-1:0] vreg_q [NREG];
	vel_pkg::vel_cfg_t cfg_q;
	logic err_q;
	logic conflict_q;
	logic [31:0] swaps_q;
	logic [4:0] preg;
	logic [VL2-1:0] boff;
	logic [16:0] max_element_count;
	logic legal;
	logic loc_ok;
	logic swap;
	logic elem_go;
	logic mask_go;
	logic tail_go;
	logic [VECTOR_REGISTER_BITS-1:0] elem_mask;
	logic [VECTOR_REGISTER_BITS-1:0] tail_mask;
	logic err_set;
	logic conflict_set;
	logic err_clr;

	// Element bit mask at the width code, bits above the element are clear
	function automatic logic [63:0] width_mask(input vel_pkg::vel_sew_t selected_element_width);
		case (selected_element_width)
			vel_pkg::VEL_E8: width_mask = 64'h0000_0000_0000_00FF;
			vel_pkg::VEL_E16: width_mask = 64'h0000_0000_0000_FFFF;
			vel_pkg::VEL_E32: width_mask = 64'h0000_0000_FFFF_FFFF;
			default: width_mask = 64'hFFFF_FFFF_FFFF_FFFF;
		endcase
	endfunction

	// ==========================================================
	// Reset release
	// Assert at once, release through two flops so no flop sees a ragged edge
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_n = rst_s2_q;

	// ==========================================================
	// Element placement
	vel_locate #(
		.VECTOR_REGISTER_BITS(VECTOR_REGISTER_BITS)
	) u_locate (
		.cfg_in(cfg_q),
		.vreg_in(elem_req_in.vreg),
		.idx_in(elem_req_in.idx),
		.preg_out(preg),
		.boff_out(boff),
		.max_element_count_out(max_element_count),
		.legal_out(legal),
		.ok_out(loc_ok)
	);

	// Width record, fed only by accepted element accesses
	vel_eew_track #(
		.NREG(NREG)
	) u_track (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.wr_in(elem_wr_in && loc_ok),
		.rd_in(elem_rd_in && loc_ok),
		.preg_in(preg),
		.eew_in(cfg_q.selected_element_width),
		.swap_out(swap)
	);

	// ==========================================================
	// Write arbitration
	// One storage write per cycle: element beats mask beats tail fill.
	// A losing request is dropped and flagged rather than queued.
	assign elem_go = elem_wr_in && loc_ok;
	assign mask_go = mask_wr_in && !elem_go && (mask_idx_in < 16'(VECTOR_REGISTER_BITS));
	assign tail_go = tail_fill_in && !elem_go && !mask_go;
	assign conflict_set = (elem_go && (mask_wr_in || tail_fill_in)) || (mask_go && tail_fill_in);
	assign err_set = ((elem_wr_in || elem_rd_in) && !loc_ok)
		|| ((mask_wr_in || mask_rd_in) && (mask_idx_in >= 16'(VECTOR_REGISTER_BITS)));

	// Slot of the current element inside its register
	assign elem_mask = VECTOR_REGISTER_BITS'(width_mask(cfg_q.selected_element_width)) << boff;

	// Tail of a fractional group: everything above multiplier times the length
	always_comb begin
		int act;
		act = VECTOR_REGISTER_BITS;
		tail_mask = '0;
		if (cfg_q.register_group_multiplier[2] && legal) begin
			act = VECTOR_REGISTER_BITS >> (8 - int'(cfg_q.register_group_multiplier));
			tail_mask = ~((VECTOR_REGISTER_BITS'(1) << act) - VECTOR_REGISTER_BITS'(1));
		end
	end

	// ==========================================================
	// Storage
	// Data is held in the plain software layout; the width record only marks
	// where a banked datapath would reshuffle, so reads never see a change.
	// No reset on the data: vector contents are undefined after reset.
	always_ff @(posedge clk_in) begin
		if (elem_go) begin
			vreg_q[preg] <= (vreg_q[preg] & ~elem_mask)
				| ((VECTOR_REGISTER_BITS'(elem_req_in.wdata) << boff) & elem_mask);
		end else if (mask_go) begin
			vreg_q[mask_reg_in][mask_idx_in[VL2-1:0]] <= mask_bit_in;
		end else if (tail_go && cfg_q.ta) begin
			vreg_q[tail_reg_in] <= vreg_q[tail_reg_in] | tail_mask;
		end
	end

	// ==========================================================
	// Element read answer, one cycle after the strobe
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			elem_rdata_out <= 64'h0;
			elem_rvalid_out <= 1'b0;
			elem_err_out <= 1'b0;
		end else begin
			elem_rvalid_out <= elem_rd_in && loc_ok;
			elem_err_out <= (elem_rd_in || elem_wr_in) && !loc_ok;
			if (elem_rd_in && loc_ok) begin
				elem_rdata_out <= 64'(vreg_q[preg] >> boff) & width_mask(cfg_q.selected_element_width);
			end
		end
	end

	// Mask bit read, bit i of one register whatever the setting
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			mask_bit_out <= 1'b0;
			mask_valid_out <= 1'b0;
		end else begin
			mask_valid_out <= mask_rd_in && (mask_idx_in < 16'(VECTOR_REGISTER_BITS));
			if (mask_rd_in && (mask_idx_in < 16'(VECTOR_REGISTER_BITS))) begin
				mask_bit_out <= vreg_q[mask_reg_in][mask_idx_in[VL2-1:0]];
			end
		end
	end

	// ==========================================================
	// Configuration register
	// Reserved grouping code is stored as written but reported illegal,
	// so software can read back what it tried.
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= vel_pkg::vel_cfg_t'(`VEL_CFG_RST);
		end else if (bus_wr_in && bus_addr_in == `VEL_OFF_CFG) begin
			cfg_q.selected_element_width <= vel_pkg::vel_sew_t'(bus_wdata_in[`VEL_CFG_SEW_MSB:`VEL_CFG_SEW_LSB]);
			cfg_q.register_group_multiplier <= bus_wdata_in[`VEL_CFG_REGISTER_GROUP_MULTIPLIER_MSB:`VEL_CFG_REGISTER_GROUP_MULTIPLIER_LSB];
			cfg_q.ta <= bus_wdata_in[`VEL_CFG_TA_BIT];
		end
	end

	// ==========================================================
	// Sticky status flags, write one to clear; a new event beats the clear
	assign err_clr = bus_wr_in && bus_addr_in == `VEL_OFF_STATUS;

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			err_q <= 1'b0;
		end else if (err_set) begin
			err_q <= 1'b1;
		end else if (err_clr && bus_wdata_in[`VEL_ST_ERR_BIT]) begin
			err_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			conflict_q <= 1'b0;
		end else if (conflict_set) begin
			conflict_q <= 1'b1;
		end else if (err_clr && bus_wdata_in[`VEL_ST_CONFLICT_BIT]) begin
			conflict_q <= 1'b0;
		end
	end

	// Count of width mismatches, any write to it zeroes it; a hit that cycle counts one
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			swaps_q <= 32'h0;
		end else if (bus_wr_in && bus_addr_in == `VEL_OFF_SWAPS) begin
			swaps_q <= {31'h0, swap};
		end else if (swap) begin
			swaps_q <= swaps_q + 32'h1;
		end
	end

	// ==========================================================
	// Register read, data stands in the cycle after the strobe only
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata_out <= 32'h0;
		end else if (bus_rd_in) begin
			case (bus_addr_in)
				`VEL_OFF_CFG: bus_rdata_out <= 32'(cfg_q);
				`VEL_OFF_STATUS: begin
					bus_rdata_out <= 32'h0;
					bus_rdata_out[`VEL_ST_LEGAL_BIT] <= legal;
					bus_rdata_out[`VEL_ST_ERR_BIT] <= err_q;
					bus_rdata_out[`VEL_ST_CONFLICT_BIT] <= conflict_q;
					bus_rdata_out[31:`VEL_ST_MAX_ELEMENT_COUNT_LSB] <= 16'(max_element_count >> 1) ; // Halved: fits 16 bits
				end
				`VEL_OFF_VLENB: bus_rdata_out <= 32'(VECTOR_REGISTER_BITS / 8);
				`VEL_OFF_SWAPS: bus_rdata_out <= swaps_q;
				default: bus_rdata_out <= 32'h0;
			endcase
		end else begin
			bus_rdata_out <= 32'h0;
		end
	end

	// Live setting shown to the datapath so it can keep the ratio steady
	assign cfg_out = cfg_q;
	assign max_element_count_out = max_element_count;

endmodule

/* dv/vel_layout_properties.sv */
// Port relations of the element layout block, bound to its top module
`timescale 1ns/10ps

module vel_layout_chk #(
	parameter int VECTOR_REGISTER_BITS = 128
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic elem_rd_in,
	input wire vel_pkg::vel_elem_req_t elem_req_in,
	input wire logic [63:0] elem_rdata_out,
	input wire logic elem_rvalid_out,
	input wire logic elem_err_out,
	input wire logic mask_rd_in,
	input wire logic [15:0] mask_idx_in,
	input wire logic mask_valid_out,
	input wire vel_pkg::vel_cfg_t cfg_out,
	input wire logic [16:0] max_element_count_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// ====================
	// Element reads
	sequence s_rd8;
		elem_rd_in && cfg_out.selected_element_width == vel_pkg::VEL_E8;
	endsequence
	chk_e8_upper_zero: assert property (s_rd8 ##1 elem_rvalid_out |-> elem_rdata_out[63:8] == 56'h0)
		else $error("byte element read carries upper bits");
	chk_unit_read_ok: assert property (elem_rd_in && cfg_out.register_group_multiplier == 3'h0 && elem_req_in.idx < max_element_count_out
		|=> elem_rvalid_out && !elem_err_out)
		else $error("in-range read not answered");
	chk_idx_refused: assert property (elem_rd_in && elem_req_in.idx >= max_element_count_out
		|=> elem_err_out && !elem_rvalid_out)
		else $error("out-of-range read not refused");
	chk_group_align: assert property (elem_rd_in && cfg_out.register_group_multiplier == 3'h1 && elem_req_in.vreg[0]
		|=> elem_err_out)
		else $error("misaligned group read accepted");

	// ====================
	// Element counts for the live setting
	chk_unit_max_element_count: assert property (cfg_out.register_group_multiplier == 3'h0 |-> max_element_count_out == 17'(VECTOR_REGISTER_BITS >> (3 + cfg_out.selected_element_width)))
		else $error("count wrong for group of one");
	chk_frac_max_element_count: assert property (cfg_out.register_group_multiplier == 3'h6 && cfg_out.selected_element_width < vel_pkg::VEL_E32
		|-> max_element_count_out == 17'(VECTOR_REGISTER_BITS >> (5 + cfg_out.selected_element_width)))
		else $error("count wrong for quarter group");
	chk_max_element_count_ratio: assert property (cfg_out.register_group_multiplier == 3'h3 |-> max_element_count_out == 17'(VECTOR_REGISTER_BITS >> cfg_out.selected_element_width))
		else $error("count wrong for group of eight");

	// ====================
	// Mask reads
	chk_mask_any_set: assert property (mask_rd_in && mask_idx_in < VECTOR_REGISTER_BITS |=> mask_valid_out)
		else $error("mask read in range not answered");
	chk_mask_beyond: assert property (mask_rd_in && mask_idx_in >= VECTOR_REGISTER_BITS |=> !mask_valid_out)
		else $error("mask read beyond register answered");
endmodule

bind vel_layout vel_layout_chk #(.VECTOR_REGISTER_BITS(VECTOR_REGISTER_BITS)) i_chk (
	.clk_in(clk_in),
	.rst_n_in(rst_n_in),
	.elem_rd_in(elem_rd_in),
	.elem_req_in(elem_req_in),
	.elem_rdata_out(elem_rdata_out),
	.elem_rvalid_out(elem_rvalid_out),
	.elem_err_out(elem_err_out),
	.mask_rd_in(mask_rd_in),
	.mask_idx_in(mask_idx_in),
	.mask_valid_out(mask_valid_out),
	.cfg_out(cfg_out),
	.max_element_count_out(max_element_count_out)
);

/* dv/vel_dp_model.sv */
// Datapath model that reads and writes elements and mask bits and fills tails
`timescale 1ns/10ps

module vel_dp_model (
	input wire logic clk_in,
	output logic elem_wr_out,
	output logic elem_rd_out,
	output vel_pkg::vel_elem_req_t elem_req_out,
	input wire logic [63:0] elem_rdata_in,
	input wire logic elem_rvalid_in,
	input wire logic elem_err_in,
	output logic mask_wr_out,
	output logic mask_rd_out,
	output logic [4:0] mask_reg_out,
	output logic [15:0] mask_idx_out,
	output logic mask_wbit_out,
	input wire logic mask_rbit_in,
	input wire logic mask_valid_in,
	output logic tail_fill_out,
	output logic [4:0] tail_reg_out
);
	// ====================
	// Idle at time zero
	initial begin
		{elem_wr_out, elem_rd_out, mask_wr_out, mask_rd_out, tail_fill_out} = 5'h00;
		elem_req_out = '0;
		{mask_reg_out, mask_idx_out, mask_wbit_out, tail_reg_out} = '0;
	end

	// One element access; released lines show the inverse, never the old value
	task automatic elem(input logic w, input logic [4:0] v, input logic [15:0] x,
		input logic [63:0] d, output logic [63:0] rd, output logic ok);
		@(posedge clk_in);
		elem_wr_out <= w;
		elem_rd_out <= !w;
		elem_req_out <= {v, x, d};
		@(posedge clk_in);
		elem_wr_out <= 1'b0;
		elem_rd_out <= 1'b0;
		elem_req_out <= ~elem_req_out;
		#1;
		rd = elem_rdata_in;
		ok = w ? !elem_err_in : elem_rvalid_in;
	endtask

	// One mask bit access
	task automatic mask(input logic w, input logic [4:0] r, input logic [15:0] x,
		input logic b, output logic rb, output logic v);
		@(posedge clk_in);
		mask_wr_out <= w;
		mask_rd_out <= !w;
		mask_reg_out <= r;
		mask_idx_out <= x;
		mask_wbit_out <= b;
		@(posedge clk_in);
		mask_wr_out <= 1'b0;
		mask_rd_out <= 1'b0;
		mask_wbit_out <= !b;
		#1;
		rb = mask_rbit_in;
		v = mask_valid_in;
	endtask

	// Tail fill of one register
	task automatic tail(input logic [4:0] r);
		@(posedge clk_in);
		tail_fill_out <= 1'b1;
		tail_reg_out <= r;
		@(posedge clk_in);
		tail_fill_out <= 1'b0;
		tail_reg_out <= ~r;
	endtask
endmodule

/* dv/vel_layout_tb.sv */
// Self-checking testbench of the element layout block
`timescale 1ns/10ps
`include "vel_defs.svh"

module vel_layout_tb;
	localparam int VECTOR_REGISTER_BITS = 128;
	logic clk_in, rst_n_in, bus_wr, bus_rd, elem_wr, elem_rd, elem_rvalid, elem_err;
	logic mask_wr, mask_rd, mask_wbit, mask_rbit, mask_valid, tail_fill, okv, mb, mv;
	logic [7:0] bus_addr;
	logic [31:0] bus_wdata, bus_rdata, rv;
	logic [63:0] elem_rdata, rdv;
	logic [4:0] mask_reg, tail_reg;
	logic [15:0] mask_idx;
	logic [16:0] max_element_count;
	vel_pkg::vel_elem_req_t elem_req;
	vel_pkg::vel_cfg_t cfg;
	int error_cnt = 0;
	int tests_run = 0;
	int i, s, c, f, k, ex;

	vel_layout #(.VECTOR_REGISTER_BITS(VECTOR_REGISTER_BITS)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.bus_addr_in(bus_addr), .bus_wdata_in(bus_wdata), .bus_wr_in(bus_wr),
		.bus_rd_in(bus_rd), .bus_rdata_out(bus_rdata), .elem_wr_in(elem_wr),
		.elem_rd_in(elem_rd), .elem_req_in(elem_req), .elem_rdata_out(elem_rdata),
		.elem_rvalid_out(elem_rvalid), .elem_err_out(elem_err), .mask_wr_in(mask_wr),
		.mask_rd_in(mask_rd), .mask_reg_in(mask_reg), .mask_idx_in(mask_idx),
		.mask_bit_in(mask_wbit), .mask_bit_out(mask_rbit), .mask_valid_out(mask_valid),
		.tail_fill_in(tail_fill), .tail_reg_in(tail_reg), .cfg_out(cfg), .max_element_count_out(max_element_count));

	vel_dp_model i_dp (.clk_in(clk_in), .elem_wr_out(elem_wr), .elem_rd_out(elem_rd),
		.elem_req_out(elem_req), .elem_rdata_in(elem_rdata), .elem_rvalid_in(elem_rvalid),
		.elem_err_in(elem_err), .mask_wr_out(mask_wr), .mask_rd_out(mask_rd),
		.mask_reg_out(mask_reg), .mask_idx_out(mask_idx), .mask_wbit_out(mask_wbit),
		.mask_rbit_in(mask_rbit), .mask_valid_in(mask_valid), .tail_fill_out(tail_fill),
		.tail_reg_out(tail_reg));

	// ====================
	// Clock and watchdog; the whole run needs well under 2000 cycles
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	initial begin
		repeat (5000) @(posedge clk_in);
		error_cnt++;
		give_verdict();
	end

	// ====================
	// Shared tasks
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk_in);
		bus_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_in);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk_in);
		bus_rd <= 1'b0;
		#1;
		rv = bus_rdata;
	endtask
	task automatic setc(input logic ta, input logic [2:0] lm, input logic [1:0] sw);
		wr(`VEL_OFF_CFG, {26'h0, ta, lm, sw});
		#1;
	endtask
	task automatic ea(input logic w, input logic [4:0] v, input logic [15:0] x, input logic [63:0] d);
		i_dp.elem(w, v, x, d, rdv, okv);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ====================
	// Test sequence
	initial begin
		{bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
		rst_n_in = 1'b0;
		repeat (6) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		rd(`VEL_OFF_CFG);
		chk("cfg", 64'(rv), 64'h0);
		chk("max_element_count_rst", 64'(max_element_count), 64'h10);
		rd(`VEL_OFF_VLENB);
		chk("vlenb", 64'(rv), 64'h10);
		rd(8'h10);
		chk("unmapped", 64'(rv), 64'h0);
		$display("test reset done");
		// Bytes in index order, read back at other widths
		setc(1'b0, 3'h0, 2'h0);
		for (i = 0; i < 16; i++) ea(1'b1, 5'h01, 16'(i), 64'hA0 + 64'(i));
		ea(1'b0, 5'h01, 16'h0005, 64'h0);
		chk("e8", rdv, 64'hA5);
		setc(1'b0, 3'h0, 2'h2);
		ea(1'b0, 5'h01, 16'h0001, 64'h0);
		chk("e32", rdv, 64'hA7A6A5A4);
		setc(1'b0, 3'h0, 2'h1);
		ea(1'b0, 5'h01, 16'h0007, 64'h0);
		chk("e16", rdv, 64'hAFAE);
		rd(`VEL_OFF_SWAPS);
		chk("swaps", 64'(rv), 64'h2);
		$display("test packing done");
		// Group of two, refused misaligned write leaves data alone
		setc(1'b0, 3'h1, 2'h2);
		ea(1'b1, 5'h02, 16'h0004, 64'h11223344);
		ea(1'b1, 5'h03, 16'h0000, 64'h55);
		chk("align", 64'(okv), 64'h0);
		ea(1'b0, 5'h02, 16'h0008, 64'h0);
		chk("grp_lim", 64'(okv), 64'h0);
		rd(`VEL_OFF_STATUS);
		chk("status", 64'(rv), 64'h0004_0003);
		setc(1'b0, 3'h0, 2'h2);
		ea(1'b0, 5'h03, 16'h0000, 64'h0);
		chk("grp_reg", rdv, 64'h11223344);
		$display("test group done");
		// Quarter group with agnostic tail
		setc(1'b1, 3'h6, 2'h0);
		chk("vl_frac", 64'(max_element_count), 64'h4);
		rd(`VEL_OFF_CFG);
		chk("cfg_ta", 64'(rv), 64'h38);
		ea(1'b0, 5'h01, 16'h0004, 64'h0);
		chk("frac_lim", 64'(okv), 64'h0);
		i_dp.tail(5'h01);
		setc(1'b0, 3'h0, 2'h0);
		ea(1'b0, 5'h01, 16'h0004, 64'h0);
		chk("tail", rdv, 64'hFF);
		ea(1'b0, 5'h01, 16'h0003, 64'h0);
		chk("kept", rdv, 64'hA3);
		$display("test tail done");
		// Every width and group code; equal ratios give equal counts
		for (s = 0; s < 4; s++) begin
			for (c = 0; c < 8; c++) begin
				setc(1'b0, 3'(c), 2'(s));
				f = (c > 4) ? 8 - c : 0;
				k = (c < 4) ? c : 0;
				ex = (c == 4 || 3 + s + f > 6) ? 0 : (VECTOR_REGISTER_BITS << k) >> (3 + s + f);
				chk("max_element_count_tab", 64'(max_element_count), 64'(ex));
			end
		end
		$display("test counts done");
		// Mask bits live in one register at any setting; clear the byte at a legal setting first
		setc(1'b0, 3'h0, 2'h0);
		ea(1'b1, 5'h04, 16'h0001, 64'h0);
		setc(1'b0, 3'h3, 2'h3);
		i_dp.mask(1'b1, 5'h04, 16'h0009, 1'b1, mb, mv);
		i_dp.mask(1'b0, 5'h04, 16'h007F, 1'b0, mb, mv);
		chk("mask_top", 64'(mv), 64'h1);
		i_dp.mask(1'b0, 5'h04, 16'h0080, 1'b0, mb, mv);
		chk("mask_out", 64'(mv), 64'h0);
		i_dp.mask(1'b0, 5'h04, 16'h0009, 1'b0, mb, mv);
		chk("mask_rd", 64'(mb), 64'h1);
		setc(1'b0, 3'h0, 2'h0);
		ea(1'b0, 5'h04, 16'h0001, 64'h0);
		chk("mask_bit", rdv, 64'h02);
		$display("test mask done");
		give_verdict();
	end
endmodule
